// ==== rtl/sar_adc_sequencer.v ====
// SAR converter sequencer with AHB-Lite register slave and per-channel results
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "sar_adc_sequencer_regs.vh"

module sar_adc_sequencer (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire pwm_trigger,
  input wire external_start_pin,
  output reg conv_start,
  output reg [2:0] conv_channel,
  output reg conv_diff,
  output reg [1:0] ch7_source,
  input wire conv_done,
  input wire [11:0] conv_data,
  output wire adc_busy,
  output wire irq
);

  localparam S_IDLE = 2'h0;
  localparam S_CONV = 2'h1;
  localparam S_NEXT = 2'h2;

  reg [31:0] ctrl_reg;
  reg [7:0] chen_reg;
  reg [11:0] cmp_reg;
  reg [2:0] stat_reg;
  reg [2:0] mask_reg;
  // One word per channel; eight words are few enough for flops
  reg [11:0] result_reg [0:7];
  reg [7:0] valid_reg;
  reg [7:0] ovr_reg;
  reg [1:0] state_reg;
  reg [2:0] chan_reg;
  reg [31:0] rd_word;
  reg [2:0] pwm_sync_reg;
  reg [2:0] ext_sync_reg;
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg [11:0] addr_reg;
  integer i;

  // Lowest enabled channel at or above the given index; found flag in bit 3
  function [3:0] next_chan;
    input [7:0] en;
    input [2:0] from;
    integer k;
    reg hit;
    begin
      hit = 1'b0;
      next_chan = 4'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (en[k] && (k >= from)) begin
          next_chan = {1'b1, k[2:0]};
          hit = 1'b1;
        end
      end
    end
  endfunction

  // Result index for an address in the result window, bit 3 marks a hit
  function [3:0] res_index;
    input [11:0] a;
    begin
      if ({a[11:5], 5'h00} == `OFS_RES0)
        res_index = {1'b1, a[4:2]};
      else
        res_index = 4'h0;
    end
  endfunction

  wire [1:0] mode = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire [3:0] first_hit = next_chan(chen_reg, 3'h0);
  // Channel 7 ends a pass; wrapping is decided separately for continuous mode
  wire [3:0] after_hit = (chan_reg == 3'h7) ? 4'h0 : next_chan(chen_reg, chan_reg + 3'h1);
  wire [3:0] wr_res = res_index(addr_reg);
  wire [3:0] rd_res = res_index(haddr);

  // Pins pass two flops; the third stage only feeds edge detection
  wire pwm_edge = pwm_sync_reg[1] & ~pwm_sync_reg[2];
  wire ext_edge = ext_sync_reg[1] & ~ext_sync_reg[2];
  // An address phase is taken when the slave is selected, the bus is ready and htrans is NONSEQ or SEQ
  wire take = hsel & hready & htrans[1];
  wire sw_write = wr_pend_reg && (addr_reg == `OFS_CTRL) && hwdata[`CTRL_START];
  // Triggers only arm the start bit; the sequencer takes it when idle
  wire hw_trig = (ctrl_reg[`CTRL_PWM_EN] & pwm_edge) |
                 (ctrl_reg[`CTRL_EXT_EN] & ext_edge);
  wire rd_result = take & ~hwrite & rd_res[3];
  wire done_ok = (state_reg == S_CONV) && conv_done;
  wire cmp_match = ctrl_reg[`CTRL_CMP_GE] ? (conv_data >= cmp_reg) :
                   (conv_data < cmp_reg);
  wire start_now = ctrl_reg[`CTRL_EN] && (state_reg == S_IDLE) && ctrl_reg[`CTRL_START];
  // Continuous mode wraps to the lowest channel only while start stays set
  wire cont_again = (mode == `MODE_CONT) && ctrl_reg[`CTRL_START] && first_hit[3];
  wire stop_now = (mode == `MODE_SINGLE) || !ctrl_reg[`CTRL_EN];

  // A read landing with a new result on the same channel consumes the old one
  wire same_read = rd_result && (rd_res[2:0] == chan_reg);
  wire ovr_hit = done_ok && valid_reg[chan_reg] && !same_read;
  wire ovr_clr = wr_pend_reg && wr_res[3] && hwdata[`RES_OVR];
  wire wr_stat = wr_pend_reg && (addr_reg == `OFS_STAT);
  wire [2:0] stat_clr = wr_stat ? hwdata[2:0] : 3'h0;
  wire [2:0] stat_set;

  assign stat_set[`ST_DONE] = done_ok;
  assign stat_set[`ST_CMP] = done_ok & ctrl_reg[`CTRL_CMP_EN] & cmp_match;
  assign stat_set[`ST_OVR] = ovr_hit;

  // Every register answers at once, so the slave never inserts wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign adc_busy = (state_reg != S_IDLE);
  assign irq = |(stat_reg & mask_reg);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_sync_reg <= 3'h0;
      ext_sync_reg <= 3'h0;
    end else begin
      pwm_sync_reg <= {pwm_sync_reg[1:0], pwm_trigger};
      ext_sync_reg <= {ext_sync_reg[1:0], external_start_pin};
    end
  end

  // Bus address phase capture; narrower writes are dropped silently
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
    end else begin
      wr_pend_reg <= take & hwrite & (hsize == 3'h2);
      rd_pend_reg <= take & ~hwrite;
      if (take)
        addr_reg <= haddr;
    end
  end

  // Read mux; the word is registered at the address phase and stands in the data phase
  always @* begin
    rd_word = 32'h00000000;
    if (rd_res[3]) begin
      rd_word = {14'h0000, ovr_reg[rd_res[2:0]], valid_reg[rd_res[2:0]],
                 4'h0, result_reg[rd_res[2:0]]};
    end else begin
      case (haddr)
        `OFS_CTRL: rd_word = ctrl_reg;
        `OFS_CHEN: rd_word = {24'h000000, chen_reg};
        `OFS_CMP: rd_word = {20'h00000, cmp_reg};
        `OFS_STAT: rd_word = {27'h0000000, adc_busy, chan_reg, 1'b0} |
                             {29'h00000000, stat_reg};
        `OFS_MASK: rd_word = {29'h00000000, mask_reg};
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // Configuration registers; the start bit is also cleared by hardware
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `CTRL_RESET;
      chen_reg <= `CHEN_RESET;
      cmp_reg <= `CMP_RESET;
      mask_reg <= `MASK_RESET;
    end else begin
      if (wr_pend_reg) begin
        case (addr_reg)
          `OFS_CTRL: ctrl_reg <= {18'h00000, hwdata[13:0]};
          `OFS_CHEN: chen_reg <= hwdata[7:0];
          `OFS_CMP: cmp_reg <= hwdata[11:0];
          `OFS_MASK: mask_reg <= hwdata[2:0];
          default: ;
        endcase
      end
      // Software writing start as one beats a same-cycle hardware clear
      if (!sw_write) begin
        if (hw_trig && ctrl_reg[`CTRL_EN])
          ctrl_reg[`CTRL_START] <= 1'b1;
        else if (start_now && mode != `MODE_CONT)
          ctrl_reg[`CTRL_START] <= 1'b0;
      end
    end
  end

  // Sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
      chan_reg <= 3'h0;
      conv_start <= 1'b0;
      conv_channel <= 3'h0;
      conv_diff <= 1'b0;
      ch7_source <= 2'h0;
    end else begin
      // Start is a one-cycle pulse; the core latches channel and source with it
      conv_start <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          // A scan with no channel enabled stays idle; the start is consumed except in continuous mode
          if (start_now) begin
            if (mode == `MODE_SINGLE) begin
              chan_reg <= ctrl_reg[`CTRL_CH_HI:`CTRL_CH_LO];
              state_reg <= S_NEXT;
            end else if (first_hit[3]) begin
              chan_reg <= first_hit[2:0];
              state_reg <= S_NEXT;
            end
          end
        end
        S_NEXT: begin
          conv_start <= 1'b1;
          if (ctrl_reg[`CTRL_DIFF])
            conv_channel <= {1'b0, chan_reg[1:0]};
          else
            conv_channel <= chan_reg;
          conv_diff <= ctrl_reg[`CTRL_DIFF];
          ch7_source <= ctrl_reg[`CTRL_CH7_HI:`CTRL_CH7_LO];
          state_reg <= S_CONV;
        end
        S_CONV: begin
          // Clearing start in continuous mode lets the pass in flight finish
          if (conv_done) begin
            if (stop_now)
              state_reg <= S_IDLE;
            else if (after_hit[3]) begin
              chan_reg <= after_hit[2:0];
              state_reg <= S_NEXT;
            end else if (cont_again) begin
              chan_reg <= first_hit[2:0];
              state_reg <= S_NEXT;
            end else
              state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Result store, valid and overrun; a new result beats a read in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_reg <= 8'h00;
      ovr_reg <= 8'h00;
      for (i = 0; i < 8; i = i + 1)
        result_reg[i] <= 12'h000;
    end else begin
      if (rd_result)
        valid_reg[rd_res[2:0]] <= 1'b0;
      if (done_ok) begin
        result_reg[chan_reg] <= conv_data;
        valid_reg[chan_reg] <= 1'b1;
        if (ovr_hit)
          ovr_reg[chan_reg] <= 1'b1;
      end
      // Overrun clear loses to a same-cycle overrun on that channel
      if (ovr_clr && !(ovr_hit && chan_reg == wr_res[2:0]))
        ovr_reg[wr_res[2:0]] <= 1'b0;
    end
  end

  // Sticky status: hardware set wins over write-one-to-clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= 3'h0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | stat_set;
    end
  end

endmodule

// ==== rtl/sar_adc_sequencer_regs.vh ====
// Register offsets, field positions, reset values and timing for the SAR sequencer
`ifndef SAR_ADC_SEQUENCER_REGS_VH
`define SAR_ADC_SEQUENCER_REGS_VH

`define OFS_CTRL 12'h000
`define OFS_CHEN 12'h004
`define OFS_CMP 12'h008
`define OFS_STAT 12'h00C
`define OFS_MASK 12'h010
`define OFS_RES0 12'h020

`define CTRL_EN 0
`define CTRL_START 1
`define CTRL_MODE_LO 2
`define CTRL_MODE_HI 3
`define CTRL_CH_LO 4
`define CTRL_CH_HI 6
`define CTRL_DIFF 7
`define CTRL_PWM_EN 8
`define CTRL_EXT_EN 9
`define CTRL_CMP_EN 10
`define CTRL_CMP_GE 11
`define CTRL_CH7_LO 12
`define CTRL_CH7_HI 13

`define MODE_SINGLE 2'h0
`define MODE_SCAN 2'h1
`define MODE_CONT 2'h3

`define ST_DONE 0
`define ST_CMP 1
`define ST_OVR 2

`define RES_VALID 16
`define RES_OVR 17

`define CTRL_RESET 32'h00000000
`define CHEN_RESET 8'h00
`define CMP_RESET 12'h000
`define MASK_RESET 3'h0

`define CONV_CYCLES 5'h10

`endif

// ==== tb/sar_adc_sequencer_properties.sv ====
// Port-level checks on the SAR sequencer
`timescale 1ns/1ps
module sar_adc_sequencer_properties (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire conv_start,
  input wire [2:0] conv_channel,
  input wire conv_diff,
  input wire [1:0] ch7_source,
  input wire conv_done,
  input wire adc_busy
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not zero-wait OKAY");
  property p_rise; $rose(adc_busy) |-> ##[0:3] conv_start; endproperty
  a_rise: assert property (p_rise) else $error("busy without start");
  property p_gap; conv_start |=> !conv_start [*2]; endproperty
  a_gap: assert property (p_gap) else $error("start too soon");
  property p_done; conv_done |-> !conv_start; endproperty
  a_done: assert property (p_done) else $error("start with done");
  property p_busy; conv_start |-> adc_busy; endproperty
  a_busy: assert property (p_busy) else $error("start while idle");
  property p_diff; conv_start && conv_diff |-> !conv_channel[2]; endproperty
  a_diff: assert property (p_diff) else $error("pair out of range");
  property p_src; ch7_source != 2'h3; endproperty
  a_src: assert property (p_src) else $error("bad source");
  property p_hold; conv_start |=> $stable(conv_channel) && $stable(conv_diff); endproperty
  a_hold: assert property (p_hold) else $error("channel moved");
endmodule
bind sar_adc_sequencer sar_adc_sequencer_properties u_props (.*);

// ==== tb/sar_core_model.sv ====
// Converter core model answering each start after lat cycles
`timescale 1ns/1ps
module sar_core_model (
  input wire hclk,
  input wire hresetn,
  input wire [4:0] lat,
  input wire conv_start,
  input wire [2:0] conv_channel,
  input wire conv_diff,
  input wire [1:0] ch7_source,
  output reg conv_done,
  output reg [11:0] conv_data
);
  reg [4:0] cnt;
  reg [5:0] req;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 5'h00;
      req <= 6'h00;
      conv_done <= 1'b0;
      conv_data <= 12'hA5A;
    end else begin
      if (conv_start) begin
        cnt <= lat;
        req <= {conv_diff, ch7_source, conv_channel};
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
      conv_done <= (cnt == 5'h01);
      // Toggles outside done so a stale sample cannot pass
      conv_data <= (cnt == 5'h01) ? {req[5], 1'b0, req[4:3], 5'h00, req[2:0]} : ~conv_data;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the SAR sequencer
`timescale 1ns/1ps
`include "sar_adc_sequencer_regs.vh"
module testbench;
  reg hclk = 0;
  reg hresetn = 0;
  reg hsel = 0;
  reg [11:0] haddr = 12'h000;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 0;
  reg [31:0] hwdata = 32'h00000000;
  reg pwm_trigger = 0;
  reg external_start_pin = 0;
  reg [4:0] lat = 5'h01;
  wire [31:0] hrdata;
  wire hreadyout, conv_start, conv_diff, conv_done, adc_busy, irq;
  wire [2:0] conv_channel;
  wire [1:0] ch7_source;
  wire [11:0] conv_data;
  integer failures = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer i;
  reg [2:0] seen[$];
  always #10 hclk = ~hclk;
  sar_adc_sequencer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .pwm_trigger(pwm_trigger),
    .external_start_pin(external_start_pin), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_diff(conv_diff), .ch7_source(ch7_source),
    .conv_done(conv_done), .conv_data(conv_data), .adc_busy(adc_busy), .irq(irq));
  sar_core_model core (.hclk(hclk), .hresetn(hresetn), .lat(lat), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_diff(conv_diff), .ch7_source(ch7_source),
    .conv_done(conv_done), .conv_data(conv_data));
  task print_verdict;
    begin
      if (failures == 0 && n_compared > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [31:0] exp, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp, input [95:0] nm);
    begin
      bus(1'b0, a, 32'h00000000);
      chk(nm, exp, hrdata);
    end
  endtask
  // Trigger 0 runs by software, 1 by PWM, 2 by the external pin
  task run(input [31:0] ctrl, input [1:0] trig);
    begin
      bus(1'b1, `OFS_CTRL, ctrl);
      pwm_trigger <= (trig == 2'h1);
      external_start_pin <= (trig == 2'h2);
      while (!adc_busy) @(posedge hclk);
      pwm_trigger <= 1'b0;
      external_start_pin <= 1'b0;
      while (adc_busy) @(posedge hclk);
      #1;
    end
  endtask
  always @(posedge hclk) begin
    if (conv_start) seen.push_back(conv_channel);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    hsel <= 1;
    @(posedge hclk);
    rd(`OFS_CTRL, 32'h0, "ctrl");
    rd(`OFS_CHEN, 32'h0, "chen");
    rd(`OFS_MASK, 32'h0, "mask");
    rd(12'h0FC, 32'h0, "unmapped");
    run(32'h53, 2'h0);
    rd(12'h034, 32'h10005, "res5");
    rd(12'h034, 32'h5, "res5 again");
    for (i = 0; i < 3; i = i + 1) begin
      run(32'h73 | (i << 12), 2'h0);
      rd(12'h03C, 32'h10007 | (i << 8), "res7");
    end
    lat <= 5'h09;
    bus(1'b1, `OFS_CHEN, 32'h29);
    seen.delete();
    run(32'h07, 2'h0);
    chk("count", 32'h3, seen.size());
    chk("order", 32'h1D, {23'h0, seen[0], seen[1], seen[2]});
    run(32'h07, 2'h0);
    rd(12'h02C, 32'h30003, "ovr res3");
    seen.delete();
    bus(1'b1, `OFS_CTRL, 32'h0F);
    while (seen.size() < 7) @(posedge hclk);
    bus(1'b1, `OFS_CTRL, 32'h0D);
    while (adc_busy) @(posedge hclk);
    chk("cont", 32'h1D, {23'h0, seen[3], seen[4], seen[5]});
    lat <= 5'h01;
    run(32'hD3, 2'h0);
    chk("pair", 32'h1, {29'h0, seen[seen.size() - 1]});
    rd(12'h034, 32'h30801, "pair res5");
    bus(1'b1, `OFS_CMP, 32'h2);
    bus(1'b1, `OFS_STAT, 32'h7);
    bus(1'b1, `OFS_MASK, 32'h2);
    run(32'h07, 2'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    run(32'hC07, 2'h0);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, `OFS_MASK, 32'h0);
    #1;
    chk("irq mask", 32'h0, {31'h0, irq});
    run(32'h121, 2'h1);
    rd(12'h028, 32'h10002, "pwm res2");
    run(32'h241, 2'h2);
    rd(12'h030, 32'h10004, "ext res4");
    print_verdict;
  end
endmodule
